/* rtl/srsm_consts.svh */
// Purpose: constants for the firmware region steering map
// Assumes: 32-bit Avalon-MM byte addressing, 20-bit memory cycle address
// Notes:   definitions only
`ifndef SRSM_CONSTS_SVH
`define SRSM_CONSTS_SVH

`define SRSM_REG_OFF     8'h5c
`define SRSM_REG_RST     8'h00
`define SRSM_REG_MASK    8'h33
`define SRSM_UP_MSB      5
`define SRSM_UP_LSB      4
`define SRSM_LO_MSB      1
`define SRSM_LO_LSB      0
`define SRSM_FLD_RD      0
`define SRSM_FLD_WR      1
`define SRSM_REGION_MSB  19
`define SRSM_REGION_LSB  15
`define SRSM_REGION_TAG  5'h1a
`define SRSM_SEG_BIT     14
`define SRSM_ATTR_HUB    2'h0
`define SRSM_ATTR_RO     2'h1
`define SRSM_ATTR_WO     2'h2
`define SRSM_ATTR_RW     2'h3

`endif

/* rtl/srsm_pkg.sv */
// Purpose: shared types for the firmware region steering map
// Assumes: nothing
// Notes:   constants live in srsm_consts.svh
package srsm_pkg;
   typedef logic [1:0] srsm_attr_t;
   typedef enum logic {SRSM_BUS_IDLE, SRSM_BUS_ACK} srsm_bus_e;
endpackage

/* rtl/srsm_seg_steer.sv */
// Purpose: steering decision for one 16 KB segment
// Assumes: attribute field of write enable over read enable
// Notes:   combinational; the caller registers the result
`include "srsm_consts.svh"

module srsm_seg_steer (
   // attribute field
   input  wire srsm_pkg::srsm_attr_t attr,
   // memory cycle
   input  wire logic                 cyc_hit,
   input  wire logic                 cyc_write,
   // decision
   output logic                      to_dram,
   output logic                      to_hub
);

   wire logic en_bit;

   // pick the enable that matches the cycle direction
   assign en_bit  = cyc_write ? attr[`SRSM_FLD_WR]
                              : attr[`SRSM_FLD_RD];
   assign to_dram = cyc_hit & en_bit;
   assign to_hub  = cyc_hit & ~en_bit;

endmodule

/* rtl/srsm_top.sv */
// Purpose: attribute register and cycle steering for region 0D0000h-0D7FFFh
// Assumes: Avalon-MM slave, one wait state, cycle inputs on clk
// Notes:   steering answer one cycle after the cycle is presented
`include "srsm_consts.svh"

module srsm_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [3:0]        byteenable,
   input  wire logic [31:0]       writedata,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   // memory cycle to steer
   input  wire logic              mem_valid,
   input  wire logic [19:0]       mem_addr,
   input  wire logic              mem_write,
   // steering result
   output logic                   steer_valid,
   output logic                   steer_dram,
   output logic                   steer_hub,
   // current fields
   output srsm_pkg::srsm_attr_t   upper_segment_attr,
   output srsm_pkg::srsm_attr_t   lower_segment_attr
);

   ////////////////////////////////////////////////////////////////////////
   // bus slave

   srsm_pkg::srsm_bus_e bus_state;
   srsm_pkg::srsm_bus_e next_bus_state;
   logic [7:0]          next_reg;
   logic [31:0]         next_readdata;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a == ADDR_W'(`SRSM_REG_OFF));
   endfunction

   wire logic       req;
   wire logic       ack;
   wire logic       wr_hit;
   wire logic       rd_hit;
   wire logic [7:0] reg_val;

   assign req     = read | write;
   assign ack     = (bus_state == srsm_pkg::SRSM_BUS_IDLE) & req;
   assign wr_hit  = ack & write & reg_hit(address) & byteenable[0];
   assign rd_hit  = ack & read & reg_hit(address);
   assign reg_val = {2'h0, upper_segment_attr, 2'h0, lower_segment_attr};

   always_comb begin
      unique case (bus_state)
         srsm_pkg::SRSM_BUS_IDLE:
            next_bus_state = req ? srsm_pkg::SRSM_BUS_ACK
                                 : srsm_pkg::SRSM_BUS_IDLE;
         srsm_pkg::SRSM_BUS_ACK:
            next_bus_state = srsm_pkg::SRSM_BUS_IDLE;
      endcase
   end

   // reserved bits dropped on write, zero on read
   assign next_reg      = wr_hit ? (writedata[7:0] & `SRSM_REG_MASK)
                                 : reg_val;
   assign next_readdata = rd_hit ? {24'h0, reg_val} : 32'h0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_state <= srsm_pkg::SRSM_BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= 32'h0;
      end else begin
         bus_state <= next_bus_state;
         waitrequest <= ~ack;
         readdata <= next_readdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // attribute register

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         upper_segment_attr <= 2'(`SRSM_REG_RST >> `SRSM_UP_LSB);
         lower_segment_attr <= 2'(`SRSM_REG_RST);
      end else begin
         upper_segment_attr <= next_reg[`SRSM_UP_MSB:`SRSM_UP_LSB];
         lower_segment_attr <= next_reg[`SRSM_LO_MSB:`SRSM_LO_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cycle steering

   wire logic       in_region;
   wire logic [1:0] seg_hit;
   wire logic [1:0] seg_dram;
   wire logic [1:0] seg_hub;
   wire srsm_pkg::srsm_attr_t seg_attr [2];

   assign in_region   = mem_valid &
      (mem_addr[`SRSM_REGION_MSB:`SRSM_REGION_LSB] == `SRSM_REGION_TAG);
   assign seg_attr[0] = lower_segment_attr;
   assign seg_attr[1] = upper_segment_attr;

   for (genvar g = 0; g < 2; g++) begin : g_seg
      assign seg_hit[g] = in_region & (mem_addr[`SRSM_SEG_BIT] == 1'(g));
      srsm_seg_steer u_seg (
         .attr      (seg_attr[g]),
         .cyc_hit   (seg_hit[g]),
         .cyc_write (mem_write),
         .to_dram   (seg_dram[g]),
         .to_hub    (seg_hub[g])
      );
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         steer_valid <= 1'b0;
         steer_dram <= 1'b0;
         steer_hub <= 1'b0;
      end else begin
         steer_valid <= in_region;
         steer_dram <= |seg_dram;
         steer_hub <= |seg_hub;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_new_req;
      req && waitrequest && bus_state == srsm_pkg::SRSM_BUS_IDLE;
   endsequence

   sequence s_reg_write;
      s_new_req and (write && reg_hit(address) && byteenable[0]);
   endsequence

   wire logic lo_cyc;
   wire logic up_cyc;
   assign lo_cyc = in_region & ~mem_addr[`SRSM_SEG_BIT];
   assign up_cyc = in_region & mem_addr[`SRSM_SEG_BIT];

   AST_ACK_ONE_WAIT: assert property (
      s_new_req |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not after exactly one wait state");

   AST_WRITE_STORES: assert property (
      s_reg_write |=> reg_val == ($past(writedata[7:0]) & `SRSM_REG_MASK))
      else $error("register write not stored");

   AST_RESERVED_ZERO: assert property (
      readdata[7:6] == 2'h0 && readdata[3:2] == 2'h0
      && readdata[31:8] == 24'h0)
      else $error("reserved read bits not zero");

   AST_HUB_ONLY: assert property (
      lo_cyc && lower_segment_attr == `SRSM_ATTR_HUB
      |=> steer_hub && !steer_dram)
      else $error("field 00 did not go to hub");

   AST_READ_ONLY: assert property (
      up_cyc && upper_segment_attr == `SRSM_ATTR_RO
      |=> steer_dram == !$past(mem_write) && steer_hub == $past(mem_write))
      else $error("field 01 steering wrong");

   AST_WRITE_ONLY: assert property (
      lo_cyc && lower_segment_attr == `SRSM_ATTR_WO
      |=> steer_dram == $past(mem_write) && steer_hub == !$past(mem_write))
      else $error("field 10 steering wrong");

   AST_NORMAL: assert property (
      up_cyc && upper_segment_attr == `SRSM_ATTR_RW
      |=> steer_dram && !steer_hub)
      else $error("field 11 did not go to dram");

   AST_UPPER_READ: assert property (
      up_cyc && !mem_write |=> steer_dram == $past(upper_segment_attr[0]))
      else $error("upper read ignored bit 4");

   AST_LOWER_WRITE: assert property (
      lo_cyc && mem_write |=> steer_dram == $past(lower_segment_attr[1]))
      else $error("lower write ignored bit 1");

   AST_OUTSIDE: assert property (
      !in_region |=> !steer_valid && !steer_dram && !steer_hub)
      else $error("cycle outside region steered");

   // a refused write misses the register or its byte lane
   sequence s_refused_write;
      s_new_req and (write && !(reg_hit(address) && byteenable[0]));
   endsequence

   AST_READ_ANSWER: assert property (
      rd_hit |=> readdata == {24'h0, $past(reg_val)})
      else $error("read answer not the register value");

   AST_REFUSED_KEEPS: assert property (
      s_refused_write |=> $stable(reg_val))
      else $error("refused write changed the register");

   AST_IDLE_READ_ZERO: assert property (
      waitrequest |-> readdata == 32'h0)
      else $error("read data not zero outside the answer");

   AST_LOWER_READ: assert property (
      lo_cyc && !mem_write
      |=> steer_dram == $past(lower_segment_attr[`SRSM_FLD_RD]))
      else $error("lower read ignored bit 0");

   AST_UPPER_WRITE: assert property (
      up_cyc && mem_write
      |=> steer_dram == $past(upper_segment_attr[`SRSM_FLD_WR]))
      else $error("upper write ignored bit 5");

   AST_IN_REGION: assert property (
      in_region |=> steer_valid && steer_dram != steer_hub)
      else $error("cycle inside region not steered to one place");

endmodule

/* test/srsm_top_tb.sv */
// Purpose: self-checking bench for the region steering register and decode
// Assumes: Avalon-MM register bus, steering answered one cycle later
// Notes:   expected values come from the field encodings, not from the design
module srsm_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk, rstn, read, write, waitrequest;
   logic                 mem_valid, mem_write, steer_valid;
   logic                 steer_dram, steer_hub;
   logic [7:0]           address;
   logic [3:0]           byteenable;
   logic [31:0]          writedata, readdata, rd;
   logic [19:0]          mem_addr;
   logic [1:0]           f, g, fld;
   logic [19:0]          seg_addr [4];
   srsm_pkg::srsm_attr_t upper_segment_attr, lower_segment_attr;
   int                   mismatches, n_checks;
   int                   cycles = 0;
   srsm_top #(.ADDR_W(8)) u_dut (.clk(clk), .rstn(rstn), .address(address),
      .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_write(mem_write),
      .steer_valid(steer_valid), .steer_dram(steer_dram),
      .steer_hub(steer_hub), .upper_segment_attr(upper_segment_attr),
      .lower_segment_attr(lower_segment_attr));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // guards against a slave that never answers
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic cmp_w(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_b(string what, logic exp, logic got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic bus_wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
      @(posedge clk);
      write      <= 1'b1;
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic bus_rd(logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      read    <= 1'b1;
      address <= a;
      do @(posedge clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask
   // present one memory cycle and check where it went
   task automatic steer(logic [19:0] a, logic wr, logic v, logic dram);
      @(posedge clk);
      mem_valid <= 1'b1;
      mem_addr  <= a;
      mem_write <= wr;
      @(posedge clk);
      mem_valid <= 1'b0;
      #1;
      cmp_b("steer_valid", v, steer_valid);
      cmp_b("steer_dram", v & dram, steer_dram);
      cmp_b("steer_hub", v & ~dram, steer_hub);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, read, write, mem_valid, mem_write} = 5'h00;
      address    = 8'h00;
      byteenable = 4'h0;
      writedata  = 32'h0;
      mem_addr   = 20'h0;
      mismatches = 0;
      n_checks   = 0;
      seg_addr = '{20'hd4000, 20'hd7fff, 20'hd0000, 20'hd3fff};
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      bus_rd(8'h5c, rd);
      cmp_w("reset value", 32'h0, rd);
      cmp_w("attrs after reset", 32'h0,
            {28'h0, upper_segment_attr, lower_segment_attr});
      steer(20'hd4000, 1'b0, 1'b1, 1'b0);
      steer(20'hd0000, 1'b1, 1'b1, 1'b0);
      for (int c = 0; c < 4; c++) begin
         f = c[1:0];
         g = ~f;
         bus_wr(8'h5c, {24'hff, 2'b11, f, 2'b11, g}, 4'h1);
         bus_rd(8'h5c, rd);
         cmp_w("register", {24'h0, 2'b00, f, 2'b00, g}, rd);
         cmp_w("upper attr", {30'h0, f}, {30'h0, upper_segment_attr});
         cmp_w("lower attr", {30'h0, g}, {30'h0, lower_segment_attr});
         for (int k = 0; k < 4; k++) begin
            fld = (k < 2) ? f : g;
            steer(seg_addr[k], k[0], 1'b1,
                  k[0] ? fld[1] : fld[0]);
         end
      end
      bus_wr(8'h5c, 32'h0, 4'he);
      bus_wr(8'h5d, 32'h0, 4'hf);
      bus_rd(8'h5c, rd);
      cmp_w("ignored writes", 32'h30, rd);
      bus_rd(8'h5d, rd);
      cmp_w("unmapped read", 32'h0, rd);
      steer(20'hd8000, 1'b0, 1'b0, 1'b0);
      steer(20'hcffff, 1'b1, 1'b0, 1'b0);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus_rd(8'h5c, rd);
      cmp_w("value after reset", 32'h0, rd);
      steer(20'hd7fff, 1'b0, 1'b1, 1'b0);
      end_sim();
   end
endmodule
